// ==== logic/sadc_defines.svh ====
// constants for the converter control block
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_RES_BITS 10
`define SADC_CH_EXT_LAST 5'h09
`define SADC_CH_RSV_A 5'h16
`define SADC_CH_RSV_B 5'h17
`define SADC_CH_RSV_C 5'h18
`define SADC_CH_RSV_D 5'h19
`define SADC_CH_TEMP 5'h1a
`define SADC_CH_BGAP 5'h1b
`define SADC_CH_RSV_E 5'h1c
`define SADC_CH_VDD 5'h1d
`define SADC_CH_OFF 5'h1f
`define SADC_CLK_BUS 2'h0
`define SADC_CLK_BUS2 2'h1
`define SADC_CLK_ALT 2'h2
`define SADC_CLK_LOCAL 2'h3
`define SADC_SAMP_SHORT 4'h2
`define SADC_SAMP_LONG 4'h8
`define SADC_MSB 4'h9
`define SADC_SETTLE 2'h2
`endif

// ==== logic/sadc_pkg.sv ====
// types of the converter control block
package sadc_pkg;
	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_SAMPLE,
		SADC_CONVERT
	} sadc_state_t;
	typedef enum logic [1:0] {
		SADC_SRC_EXT,
		SADC_SRC_GND,
		SADC_SRC_VDD,
		SADC_SRC_INT
	} sadc_src_t;
endpackage

// ==== logic/sadc_chan_mux.sv ====
// channel code decode onto analog source selects
`include "sadc_defines.svh"
module sadc_chan_mux (
	// code
	input wire logic [4:0] i_channel_select,
	// selects
	output logic [9:0] o_pin_sel,
	output logic o_gnd_sel,
	output logic o_vdd_sel,
	output logic o_temp_sel,
	output logic o_bgap_sel,
	output logic o_reserved,
	output logic o_off
);
	// ************************************************
	// decode
	// ************************************************
	genvar g;
	generate
		for (g = 0; g < 10; g++) begin : g_pin
			assign o_pin_sel[g] = (i_channel_select == 5'(g));
		end
	endgenerate
	assign o_vdd_sel = (i_channel_select == `SADC_CH_VDD);
	assign o_temp_sel = (i_channel_select == `SADC_CH_TEMP);
	assign o_bgap_sel = (i_channel_select == `SADC_CH_BGAP);
	assign o_off = (i_channel_select == `SADC_CH_OFF);
	// reserved codes still convert, the result is meaningless
	assign o_reserved = (i_channel_select == `SADC_CH_RSV_A) ||
		(i_channel_select == `SADC_CH_RSV_B) ||
		(i_channel_select == `SADC_CH_RSV_C) ||
		(i_channel_select == `SADC_CH_RSV_D) ||
		(i_channel_select == `SADC_CH_RSV_E);
	assign o_gnd_sel = !(|o_pin_sel) && !o_vdd_sel && !o_temp_sel &&
		!o_bgap_sel && !o_off && !o_reserved;
endmodule

// ==== logic/sadc_clk_sel.sv ====
// conversion clock source selection as a tick stream on i_clk
`include "sadc_defines.svh"
module sadc_clk_sel (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// source controls
	input wire logic [1:0] i_clock_select,
	input wire logic [1:0] i_clock_divide_select,
	input wire logic i_local_async_clock,
	input wire logic i_alternate_clock,
	input wire logic i_stop_mode,
	// tick
	output logic o_tick,
	output logic o_alt_blocked
);
	logic [1:0] alt_s_q;
	logic [1:0] loc_s_q;
	logic alt_d_q;
	logic loc_d_q;
	logic half_q;
	logic src_tick;
	logic [3:0] div_q;
	logic [3:0] div_lim;
	// ************************************************
	// source edges
	// ************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			alt_s_q <= 2'h0;
			loc_s_q <= 2'h0;
			alt_d_q <= 1'b0;
			loc_d_q <= 1'b0;
			half_q <= 1'b0;
		end else begin
			alt_s_q <= {alt_s_q[0], i_alternate_clock};
			loc_s_q <= {loc_s_q[0], i_local_async_clock};
			alt_d_q <= alt_s_q[1];
			loc_d_q <= loc_s_q[1];
			half_q <= ~half_q;
		end
	end
	// alt clock keeps running in wait, but is gated in stop
	assign o_alt_blocked = i_stop_mode && (i_clock_select == `SADC_CLK_ALT);
	always_comb begin
		case (i_clock_select)
			`SADC_CLK_BUS: src_tick = 1'b1;
			`SADC_CLK_BUS2: src_tick = half_q;
			`SADC_CLK_ALT: src_tick = alt_s_q[1] && !alt_d_q &&
				!i_stop_mode;
			default: src_tick = loc_s_q[1] && !loc_d_q;
		endcase
	end
	// ************************************************
	// divider
	// ************************************************
	assign div_lim = (4'h1 << i_clock_divide_select) - 4'h1;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			div_q <= 4'h0;
		end else if (src_tick) begin
			div_q <= (div_q >= div_lim) ? 4'h0 : div_q + 4'h1;
		end
	end
	assign o_tick = src_tick && (div_q >= div_lim);
endmodule

// ==== logic/sadc_ctrl.sv ====
// successive-approximation converter control with channel and triggers
`include "sadc_defines.svh"
module sadc_ctrl (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control register write
	input wire logic i_ctrl_wr,
	input wire logic [4:0] i_channel_select,
	input wire logic i_irq_en,
	input wire logic i_continuous,
	// configuration
	input wire logic i_hw_trig_en,
	input wire logic i_cmp_en,
	input wire logic i_cmp_ge,
	input wire logic [9:0] i_cmp_value,
	input wire logic i_mode_8bit,
	input wire logic i_long_sample,
	input wire logic i_low_power,
	input wire logic [1:0] i_clock_select,
	input wire logic [1:0] i_clock_divide_select,
	input wire logic i_bandgap_buffer_enable,
	// result read
	input wire logic i_result_rd,
	// clocks and modes
	input wire logic i_local_async_clock,
	input wire logic i_alternate_clock,
	input wire logic i_stop_mode,
	input wire logic i_deep_stop,
	// periodic counter
	input wire logic i_counter_overflow,
	input wire logic i_counter_irq_enable,
	// analog side
	input wire logic i_comparator,
	output logic [9:0] o_dac_code,
	output logic o_sample_hold,
	output logic [9:0] o_pin_sel,
	output logic o_gnd_sel,
	output logic o_vdd_sel,
	output logic o_temp_sel,
	output logic o_bgap_sel,
	output logic o_analog_on,
	// status
	output logic [9:0] o_result,
	output logic o_complete,
	output logic o_irq,
	output logic o_active,
	output logic o_alt_blocked,
	output logic o_bgap_invalid
);
	sadc_pkg::sadc_state_t state_q;
	logic [4:0] chan_q;
	logic cont_q;
	logic ien_q;
	logic [1:0] ovf_s_q;
	logic ovf_d_q;
	logic hw_trig;
	logic [1:0] cmp_s_q;
	logic tick;
	logic reserved;
	logic off;
	logic [3:0] samp_q;
	logic [3:0] bit_q;
	logic [9:0] sar_q;
	logic [9:0] result_q;
	logic complete_q;
	logic done;
	logic [9:0] final_val;
	logic match;
	logic start;
	logic [3:0] samp_len;
	logic [9:0] trial;
	logic [1:0] settle_q;
	logic step;

	// ************************************************
	// submodules
	// ************************************************
	sadc_chan_mux u_mux (
		.i_channel_select(chan_q),
		.o_pin_sel(o_pin_sel),
		.o_gnd_sel(o_gnd_sel),
		.o_vdd_sel(o_vdd_sel),
		.o_temp_sel(o_temp_sel),
		.o_bgap_sel(o_bgap_sel),
		.o_reserved(reserved),
		.o_off(off)
	);
	sadc_clk_sel u_clk (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clock_select(i_clock_select),
		.i_clock_divide_select(i_clock_divide_select),
		.i_local_async_clock(i_local_async_clock),
		.i_alternate_clock(i_alternate_clock),
		.i_stop_mode(i_stop_mode),
		.o_tick(tick),
		.o_alt_blocked(o_alt_blocked)
	);

	// ************************************************
	// control register
	// ************************************************
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			chan_q <= `SADC_CH_OFF;
			cont_q <= 1'b0;
			ien_q <= 1'b0;
		end else if (i_ctrl_wr) begin
			chan_q <= i_channel_select;
			cont_q <= i_continuous;
			ien_q <= i_irq_en;
		end
	end
	// flag is only advisory: the buffer lives elsewhere
	assign o_bgap_invalid = o_bgap_sel && !i_bandgap_buffer_enable;
	assign o_analog_on = !off;

	// ************************************************
	// hardware trigger
	// ************************************************
	// counter interrupt enable deliberately unused here
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ovf_s_q <= 2'h0;
			ovf_d_q <= 1'b0;
			cmp_s_q <= 2'h0;
		end else begin
			ovf_s_q <= {ovf_s_q[0], i_counter_overflow};
			ovf_d_q <= ovf_s_q[1];
			cmp_s_q <= {cmp_s_q[0], i_comparator};
		end
	end
	// no trigger in deep stop; run, wait, shallow stop all pass
	assign hw_trig = i_hw_trig_en && ovf_s_q[1] && !ovf_d_q &&
		!i_deep_stop;
	assign start = i_hw_trig_en ? hw_trig : (i_ctrl_wr &&
		(i_channel_select != `SADC_CH_OFF));

	// ************************************************
	// sequencer
	// ************************************************
	// low power halves nothing but lengthens sampling by one tick
	assign samp_len = (i_long_sample ? `SADC_SAMP_LONG :
		`SADC_SAMP_SHORT) + {3'h0, i_low_power};
	assign trial = sar_q | (10'h001 << bit_q);
	// the comparator passes two sync stages, so a bit is only decided
	// once the answer to the current trial has reached the second stage
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			settle_q <= 2'h0;
		end else if (state_q != sadc_pkg::SADC_CONVERT || step || start) begin
			settle_q <= 2'h0;
		end else if (settle_q != `SADC_SETTLE) begin
			settle_q <= settle_q + 2'h1;
		end
	end
	assign step = (state_q == sadc_pkg::SADC_CONVERT) && tick &&
		(settle_q == `SADC_SETTLE);
	assign done = step && (bit_q == 4'h0);
	assign final_val = cmp_s_q[1] ? trial : sar_q;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= sadc_pkg::SADC_IDLE;
			samp_q <= 4'h0;
			bit_q <= 4'h0;
			sar_q <= 10'h000;
		end else if (i_ctrl_wr && i_channel_select == `SADC_CH_OFF) begin
			state_q <= sadc_pkg::SADC_IDLE;
		end else if (start) begin
			state_q <= sadc_pkg::SADC_SAMPLE;
			samp_q <= 4'h0;
			sar_q <= 10'h000;
		end else if (tick) begin
			case (state_q)
				sadc_pkg::SADC_SAMPLE: begin
					if (samp_q + 4'h1 >= samp_len) begin
						state_q <= sadc_pkg::SADC_CONVERT;
						bit_q <= `SADC_MSB;
					end else begin
						samp_q <= samp_q + 4'h1;
					end
				end
				sadc_pkg::SADC_CONVERT: begin
					if (!step) begin
						state_q <= state_q;
					end else if (bit_q != 4'h0) begin
						sar_q <= cmp_s_q[1] ? trial : sar_q;
						bit_q <= bit_q - 4'h1;
					end else begin
						samp_q <= 4'h0;
						// continuous with hw trigger waits for next one
						state_q <= (cont_q && !i_hw_trig_en && !off) ?
							sadc_pkg::SADC_SAMPLE :
							sadc_pkg::SADC_IDLE;
						sar_q <= 10'h000;
					end
				end
				default: state_q <= sadc_pkg::SADC_IDLE;
			endcase
		end
	end
	assign o_dac_code = trial;
	assign o_sample_hold = (state_q == sadc_pkg::SADC_SAMPLE);
	assign o_active = (state_q != sadc_pkg::SADC_IDLE);

	// ************************************************
	// result, compare and flag
	// ************************************************
	assign match = i_cmp_ge ? (final_val >= i_cmp_value) :
		(final_val < i_cmp_value);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			result_q <= 10'h000;
		end else if (done && (!i_cmp_en || match)) begin
			result_q <= i_mode_8bit ? {2'h0, final_val[9:2]} :
				final_val;
		end
	end
	// set wins over a read or write clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			complete_q <= 1'b0;
		end else if (done && (!i_cmp_en || match)) begin
			complete_q <= 1'b1;
		end else if (i_ctrl_wr || i_result_rd) begin
			complete_q <= 1'b0;
		end
	end
	assign o_result = result_q;
	assign o_complete = complete_q;
	assign o_irq = complete_q && ien_q;

	// ************************************************
	// checks
	// ************************************************
	sequence s_last_bit;
		step && bit_q == 4'h0;
	endsequence
	a_irq_flag: assert property (@(posedge i_clk) disable iff (i_rst)
		o_irq |-> o_complete)
		else $error("interrupt without completion flag");
	a_bit_settled: assert property (@(posedge i_clk) disable iff (i_rst)
		state_q == sadc_pkg::SADC_CONVERT && tick && settle_q == 2'h0
		&& !start && !i_ctrl_wr |=> bit_q == $past(bit_q))
		else $error("bit decided before comparator settled");
	a_single_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		s_last_bit and (!cont_q && !start && !i_ctrl_wr) |=>
		state_q == sadc_pkg::SADC_IDLE)
		else $error("single conversion did not return idle");
	a_flag_set: assert property (@(posedge i_clk) disable iff (i_rst)
		s_last_bit and !i_cmp_en |=> complete_q)
		else $error("completion flag not set");
	a_off_stops: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ctrl_wr && i_channel_select == `SADC_CH_OFF |=>
		!o_active && !o_analog_on)
		else $error("off code did not stop converter");
	a_write_start: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ctrl_wr && !i_hw_trig_en && i_channel_select != `SADC_CH_OFF
		|=> o_sample_hold && !complete_q)
		else $error("write did not restart conversion");
	a_hw_start: assert property (@(posedge i_clk) disable iff (i_rst)
		hw_trig && !i_ctrl_wr |=> o_sample_hold)
		else $error("overflow did not start conversion");
	a_eight_bit: assert property (@(posedge i_clk) disable iff (i_rst)
		i_mode_8bit && $changed(result_q) |-> result_q[9:8] == 2'h0)
		else $error("8-bit result not right justified");
	a_alt_stop: assert property (@(posedge i_clk) disable iff (i_rst)
		i_stop_mode && i_clock_select == `SADC_CLK_ALT |-> !tick)
		else $error("alternate clock ticked in stop");
	a_vdd_code: assert property (@(posedge i_clk) disable iff (i_rst)
		chan_q == `SADC_CH_VDD |-> o_vdd_sel && !o_gnd_sel
		&& o_pin_sel == 10'h000)
		else $error("supply code mis-decoded");
	a_conv_len: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(state_q == sadc_pkg::SADC_CONVERT) |-> bit_q == `SADC_MSB)
		else $error("search does not start at msb");
	a_temp_code: assert property (@(posedge i_clk) disable iff (i_rst)
		chan_q == `SADC_CH_TEMP |-> o_temp_sel && !o_bgap_sel)
		else $error("temperature code mis-decoded");
endmodule

// ==== dv/sadc_counter_model.sv ====
// periodic counter model that supplies the hardware trigger
module sadc_counter_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_run,
	input wire logic [7:0] i_period,
	// trigger
	output logic o_overflow
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] count_q;
	logic [1:0] hold_q;
	logic wrap;
	assign wrap = i_run && (count_q == i_period);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			count_q <= 8'h00;
		end else if (!i_run || wrap) begin
			count_q <= 8'h00;
		end else begin
			count_q <= count_q + 8'h01;
		end
	end
	// two cycles wide so the far edge detector cannot miss it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_q <= 2'h0;
		end else if (wrap) begin
			hold_q <= 2'h2;
		end else if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end
	end
	// no interrupt enable gates the overflow output
	assign o_overflow = (hold_q != 2'h0);
endmodule

// ==== dv/sar_adc_channel_trigger_ctrl_bench.sv ====
// self-checking bench for the converter control block
module sar_adc_channel_trigger_ctrl_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk, i_rst, i_ctrl_wr, i_irq_en, i_continuous, i_hw_trig_en;
	logic i_cmp_en, i_cmp_ge, i_mode_8bit, i_long_sample, i_low_power;
	logic i_bandgap_buffer_enable, i_result_rd, i_local_async_clock;
	logic i_alternate_clock, i_stop_mode, i_deep_stop, i_counter_overflow;
	logic i_counter_irq_enable, i_comparator;
	logic [4:0] i_channel_select;
	logic [9:0] i_cmp_value, analog;
	logic [1:0] i_clock_select, i_clock_divide_select;
	logic [9:0] o_dac_code, o_pin_sel, o_result;
	logic o_sample_hold, o_gnd_sel, o_vdd_sel, o_temp_sel, o_bgap_sel;
	logic o_analog_on, o_complete, o_irq, o_active, o_alt_blocked;
	logic o_bgap_invalid, trig_run, prev_done;
	logic [7:0] trig_period;
	logic [9:0] exp_q[$];
	int n_errors, comparisons, seed;
	sadc_ctrl u_sadc_ctrl (.i_clk(i_clk), .i_rst(i_rst),
		.i_ctrl_wr(i_ctrl_wr), .i_channel_select(i_channel_select),
		.i_irq_en(i_irq_en), .i_continuous(i_continuous),
		.i_hw_trig_en(i_hw_trig_en), .i_cmp_en(i_cmp_en), .i_cmp_ge(i_cmp_ge),
		.i_cmp_value(i_cmp_value), .i_mode_8bit(i_mode_8bit),
		.i_long_sample(i_long_sample), .i_low_power(i_low_power),
		.i_clock_select(i_clock_select),
		.i_clock_divide_select(i_clock_divide_select),
		.i_bandgap_buffer_enable(i_bandgap_buffer_enable),
		.i_result_rd(i_result_rd), .i_local_async_clock(i_local_async_clock),
		.i_alternate_clock(i_alternate_clock), .i_stop_mode(i_stop_mode),
		.i_deep_stop(i_deep_stop), .i_counter_overflow(i_counter_overflow),
		.i_counter_irq_enable(i_counter_irq_enable),
		.i_comparator(i_comparator), .o_dac_code(o_dac_code),
		.o_sample_hold(o_sample_hold), .o_pin_sel(o_pin_sel),
		.o_gnd_sel(o_gnd_sel), .o_vdd_sel(o_vdd_sel), .o_temp_sel(o_temp_sel),
		.o_bgap_sel(o_bgap_sel), .o_analog_on(o_analog_on),
		.o_result(o_result), .o_complete(o_complete), .o_irq(o_irq),
		.o_active(o_active), .o_alt_blocked(o_alt_blocked),
		.o_bgap_invalid(o_bgap_invalid));
	sadc_counter_model u_sadc_counter_model (.i_clk(i_clk), .i_rst(i_rst),
		.i_run(trig_run), .i_period(trig_period),
		.o_overflow(i_counter_overflow));
	// analog input model: comparator against the trial code
	assign i_comparator = (analog >= o_dac_code);
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		i_local_async_clock = 1'b0;
		forever #17 i_local_async_clock = ~i_local_async_clock;
	end
	initial begin
		i_alternate_clock = 1'b0;
		#3;
		forever #13 i_alternate_clock = ~i_alternate_clock;
	end
	// ****************************************
	// tasks
	// ****************************************
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, g);
		comparisons++;
		if (e !== g) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic tick;
		@(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] ch, input logic cont);
		i_channel_select = ch;
		i_continuous = cont;
		i_ctrl_wr = 1'b1;
		tick;
		i_ctrl_wr = 1'b0;
		tick;
	endtask
	task automatic rd;
		i_result_rd = 1'b1;
		tick;
		i_result_rd = 1'b0;
		tick;
	endtask
	task automatic wait_for(input logic want_done);
		int k;
		for (k = 0; k < 2000; k++) begin
			if (want_done ? o_complete === 1'b1 : o_active === 1'b0) break;
			tick;
		end
		if (k == 2000) begin
			n_errors++;
			$display("Error wait expected %b seen timeout", want_done);
			give_verdict;
		end
	endtask
	// picks a fresh input level and notes the result it must give
	task automatic arm;
		analog = {1'b0, 9'($random(seed))};
		exp_q.push_back(i_mode_8bit ? {2'h0, analog[9:2]} : analog);
	endtask
	function automatic logic [15:0] dec_exp(input logic [4:0] c, input logic bg);
		logic [9:0] pins;
		pins = (c <= 5'h09) ? (10'h001 << c) : 10'h000;
		return {pins, (c inside {[5'h0a:5'h15], 5'h1e}), c == 5'h1d,
			c == 5'h1a, c == 5'h1b, c == 5'h1b && !bg, c != 5'h1f};
	endfunction
	// result watcher: oldest note against each new completion
	always @(negedge i_clk) begin
		if (i_rst === 1'b0 && o_complete === 1'b1 && prev_done !== 1'b1) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("Error completion expected none seen %h", o_result);
			end else begin
				chk("result", 16'(exp_q.pop_front()), 16'(o_result));
			end
		end
		prev_done = o_complete;
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seed = 32'hfcfe;
		{i_ctrl_wr, i_irq_en, i_continuous, i_hw_trig_en, i_cmp_en} = '0;
		{i_cmp_ge, i_mode_8bit, i_long_sample, i_low_power} = '0;
		{i_bandgap_buffer_enable, i_result_rd, i_stop_mode, i_deep_stop} = '0;
		{i_counter_irq_enable, trig_run, prev_done} = '0;
		i_channel_select = 5'h1f;
		i_cmp_value = 10'h000;
		i_clock_select = 2'h0;
		i_clock_divide_select = 2'h0;
		analog = 10'h000;
		trig_period = 8'hc0;
		n_errors = 0;
		comparisons = 0;
		i_rst = 1'b1;
		repeat (6) @(posedge i_clk);
		#1 i_rst = 1'b0;
		for (int i = 0; i < 64; i++) begin
			i_bandgap_buffer_enable = i[5];
			wr(i[4:0], 1'b0);
			chk("decode", dec_exp(i[4:0], i[5]), {o_pin_sel, o_gnd_sel, o_vdd_sel,
				o_temp_sel, o_bgap_sel, o_bgap_invalid, o_analog_on});
		end
		$display("test decode done");
		for (int i = 0; i < 16; i++) begin
			{i_irq_en, i_mode_8bit, i_low_power, i_long_sample} = 4'(i);
			arm;
			wr(5'h00, 1'b0);
			wait_for(1'b1);
			chk("irq", 16'(i_irq_en), 16'(o_irq));
			tick;
			chk("active", 16'h0, 16'(o_active));
			rd;
			chk("complete", 16'h0, 16'(o_complete));
		end
		$display("test modes done");
		i_mode_8bit = 1'b0;
		for (int s = 0; s < 4; s++) begin
			i_clock_select = 2'(s);
			i_clock_divide_select = 2'(s);
			i_stop_mode = 1'b1;
			tick;
			chk("alt_blocked", 16'(s == 2), 16'(o_alt_blocked));
			i_stop_mode = 1'b0;
			arm;
			wr(5'h03, 1'b0);
			wait_for(1'b1);
			rd;
		end
		{i_clock_select, i_clock_divide_select} = 4'h0;
		$display("test clocks done");
		i_cmp_en = 1'b1;
		for (int k = 0; k < 4; k++) begin
			arm;
			i_cmp_ge = k[1];
			i_cmp_value = analog + 10'(k[0]);
			if (!(k[1] ^ k[0])) void'(exp_q.pop_back());
			wr(5'h01, 1'b0);
			if (k[1] ^ k[0]) begin
				wait_for(1'b1);
				rd;
			end else begin
				wait_for(1'b0);
				chk("cmp_miss", 16'h0, 16'(o_complete));
			end
		end
		i_cmp_en = 1'b0;
		$display("test compare done");
		i_hw_trig_en = 1'b1;
		wr(5'h02, 1'b0);
		chk("hw_idle", 16'h0, 16'(o_active));
		for (int m = 0; m < 2; m++) begin
			i_stop_mode = m[0];
			i_clock_select = m[0] ? 2'h3 : 2'h0;
			arm;
			trig_run = 1'b1;
			wait_for(1'b1);
			trig_run = 1'b0;
			rd;
		end
		i_deep_stop = 1'b1;
		trig_run = 1'b1;
		repeat (400) tick;
		{trig_run, i_deep_stop, i_stop_mode, i_hw_trig_en} = '0;
		i_clock_select = 2'h0;
		$display("test trigger done");
		arm;
		wr(5'h04, 1'b0);
		void'(exp_q.pop_back());
		repeat (4) tick;
		arm;
		wr(5'h04, 1'b1);
		for (int n = 0; n < 2; n++) begin
			wait_for(1'b1);
			if (n == 0) exp_q.push_back(analog);
			rd;
		end
		wr(5'h1f, 1'b0);
		wait_for(1'b0);
		repeat (60) tick;
		chk("off_active", 16'h0, 16'(o_active));
		chk("leftover", 16'h0, 16'(exp_q.size()));
		$display("test continuous done");
		give_verdict;
	end
endmodule
